// file: core/lbc_pkg.sv
// Constants and types for the break-point lineariser and its set-up menu.
// Assumes one 50 MHz clock and debounced one-cycle push-button pulses.
package lbc_pkg;
    // Table geometry
    localparam int LBC_MAX_PTS = 17;
    localparam int LBC_MIN_PTS = 2;
    localparam logic [4:0] LBC_MAX_CNT = 5'h11;
    localparam logic [4:0] LBC_MIN_CNT = 5'h02;
    localparam logic [4:0] LBC_LAST_IDX = 5'h10;
    localparam logic [4:0] LBC_IDX_ONE = 5'h01;
    localparam logic [4:0] LBC_IDX_ZERO = 5'h00;
    // Currents in microamps, 16 bits
    localparam logic [15:0] LBC_CUR_MIN = 16'h0ED8;   // 3.8 mA
    localparam logic [15:0] LBC_CUR_MAX = 16'h5208;   // 21.0 mA
    localparam logic [15:0] LBC_CUR_LOW = 16'h0708;   // 1.8 mA
    localparam logic [15:0] LBC_DEF_CUR0 = 16'h0FA0;  // 4 mA
    localparam logic [15:0] LBC_DEF_CUR1 = 16'h4E20;  // 20 mA
    localparam logic [15:0] LBC_CUR_STEP = 16'h0001;
    // Display values in counts of the least digit, signed
    localparam logic signed [19:0] LBC_DEF_DSP0 = 20'sh00000;
    localparam logic signed [19:0] LBC_DEF_DSP1_4D = 20'sh003E8;  // 100.0
    localparam logic signed [19:0] LBC_DEF_DSP1_5D = 20'sh02710;  // 100.00
    localparam logic signed [19:0] LBC_DSP_MAX_4D = 20'sh0270F;   // 9999
    localparam logic signed [19:0] LBC_DSP_MAX_5D = 20'sh1869F;   // 99999
    localparam logic signed [19:0] LBC_DSP_STEP = 20'sh00001;
    // Digit editing
    localparam logic [2:0] LBC_DIGITS = 3'h5;
    localparam logic [2:0] LBC_DIG_ZERO = 3'h0;

    typedef enum logic [9:0] {
        LBC_M_ADD_PROMPT = 10'h001,
        LBC_M_DEL_PROMPT = 10'h002,
        LBC_M_IN_PROMPT  = 10'h004,
        LBC_M_DSP_PROMPT = 10'h008,
        LBC_M_ADD_SUB    = 10'h010,
        LBC_M_DEL_SUB    = 10'h020,
        LBC_M_IN_IDX     = 10'h040,
        LBC_M_IN_EDIT    = 10'h080,
        LBC_M_DSP_IDX    = 10'h100,
        LBC_M_DSP_EDIT   = 10'h200
    } lbc_mode_t;
endpackage : lbc_pkg

// file: core/lbc_lineariser.sv
// Break-point lineariser with its front-panel set-up menu.
// Assumes buttons are one-cycle pulses from same-clock logic; the loop current
// arrives as a binary microamp word already synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Add inserts before shown point, shifts later
// - Delete removes shown point, shifts later down
// - Each proceed adds one, refuse beyond 17
// - Each proceed deletes one, keep at least 2
// - Up/down move the selected position
// - Sub-functions show index and total count
// - Exit returns to last used add/delete prompt
// - Current set by up/down steps of 1uA, no input needed
// - Current: index prompt from zero, edit, exit
// - Display value uses the same sequence
// - Two exits return to calibration entry
// - Reject current not strictly between neighbours
// - Reject current outside 3.8 to 21.0mA
// - Below point zero extend first slope
// - Above last point extend last slope
// - Range indications unchanged by lineariser
// - Show low loop power message below 1.8mA
// - Restore gives 4mA->0, 20mA->100
// - Out of range flashes points, sign shows under
// - Up to sixteen segments, points 0 to 16
// - Table persists across function changes
module lbc_lineariser (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_btn_up,
    input wire logic i_btn_down,
    input wire logic i_btn_proceed,
    input wire logic i_btn_exit,
    input wire logic i_enter_menu,
    input wire logic i_restore_defaults_cmd,
    input wire logic i_five_digit,
    input wire logic i_lin_enable,
    input wire logic [15:0] i_loop_current,
    input wire logic signed [19:0] i_linear_value,
    output logic [9:0] o_menu_state,
    output logic [4:0] o_sel_index,
    output logic [4:0] o_point_count,
    output logic [2:0] o_edit_digit,
    output logic [19:0] o_edit_value,
    output logic o_fail_msg,
    output logic o_menu_exit,
    output logic signed [19:0] o_display_value,
    output logic o_over_range,
    output logic o_under_range,
    output logic o_low_loop_power_msg
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        lbc_pkg::lbc_mode_t mode;
        logic last_was_del;
        logic [4:0] sel;
        logic [4:0] count;
        logic [2:0] digit;
        logic [19:0] edit;
        logic fail;
        logic exit_pulse;
        logic [lbc_pkg::LBC_MAX_PTS*16-1:0] cur;
        logic [lbc_pkg::LBC_MAX_PTS*20-1:0] dsp;
        logic signed [19:0] point_value_subfn;
        logic over;
        logic under;
        logic low;
    } lbc_state_t;

    lbc_state_t st;
    lbc_state_t next_st;

    // ---------------------------------------------------------------
    // Table views and segment search
    // ---------------------------------------------------------------
    logic [15:0] cur_tab [lbc_pkg::LBC_MAX_PTS];
    logic signed [19:0] dsp_tab [lbc_pkg::LBC_MAX_PTS];
    logic [lbc_pkg::LBC_MAX_PTS-1:0] above;

    genvar g;
    generate
        for (g = 0; g < lbc_pkg::LBC_MAX_PTS; g++) begin : g_view
            assign cur_tab[g] = st.cur[g*16 +: 16];
            assign dsp_tab[g] = st.dsp[g*20 +: 20];
            // Point g lies at or below the input and is not the last point
            assign above[g] = (5'(g) < st.count - lbc_pkg::LBC_IDX_ONE)
                && (i_loop_current >= cur_tab[g]);
        end
    endgenerate

    // Segment start: highest point at or below input, clamped so both ends
    // extend the outer segments
    logic [4:0] seg;
    always_comb begin
        seg = lbc_pkg::LBC_IDX_ZERO;
        for (int k = 1; k < lbc_pkg::LBC_MAX_PTS; k++) begin
            if (above[k]) begin
                seg = 5'(k);
            end
        end
    end

    logic [15:0] x0, x1;
    logic signed [19:0] y0, y1;
    logic signed [47:0] num;
    logic signed [47:0] interp;
    logic signed [19:0] dsp_max;
    logic signed [19:0] src;
    assign x0 = cur_tab[seg];
    assign x1 = cur_tab[seg + lbc_pkg::LBC_IDX_ONE];
    assign y0 = dsp_tab[seg];
    assign y1 = dsp_tab[seg + lbc_pkg::LBC_IDX_ONE];
    // Divider is combinational; one-cycle latency is fine for a slow display
    assign num = 48'(signed'({1'b0, i_loop_current}) - signed'({1'b0, x0}))
        * 48'(y1 - y0);
    assign interp = 48'(y0) + num / 48'(signed'({1'b0, x1}) - signed'({1'b0, x0}));
    assign dsp_max = i_five_digit ? lbc_pkg::LBC_DSP_MAX_5D : lbc_pkg::LBC_DSP_MAX_4D;
    assign src = i_lin_enable ? 20'(interp) : i_linear_value;

    // Candidate current for validation
    logic [15:0] cand;
    logic cand_ok;
    logic [4:0] nxt_idx;
    assign cand = st.edit[15:0];
    assign nxt_idx = st.sel + lbc_pkg::LBC_IDX_ONE;
    always_comb begin
        cand_ok = (cand >= lbc_pkg::LBC_CUR_MIN) && (cand <= lbc_pkg::LBC_CUR_MAX);
        if (st.sel != lbc_pkg::LBC_IDX_ZERO && cand <= cur_tab[st.sel - lbc_pkg::LBC_IDX_ONE]) begin
            cand_ok = 1'b0;
        end
        if (nxt_idx < st.count && cand >= cur_tab[nxt_idx]) begin
            cand_ok = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.exit_pulse = 1'b0;
        unique case (st.mode)
            lbc_pkg::LBC_M_ADD_PROMPT, lbc_pkg::LBC_M_DEL_PROMPT,
            lbc_pkg::LBC_M_IN_PROMPT, lbc_pkg::LBC_M_DSP_PROMPT: begin
                if (i_btn_up || i_btn_down) begin
                    next_st.mode = (st.mode == lbc_pkg::LBC_M_ADD_PROMPT)
                        ? (i_btn_up ? lbc_pkg::LBC_M_DEL_PROMPT : lbc_pkg::LBC_M_DSP_PROMPT)
                        : (st.mode == lbc_pkg::LBC_M_DEL_PROMPT)
                        ? (i_btn_up ? lbc_pkg::LBC_M_IN_PROMPT : lbc_pkg::LBC_M_ADD_PROMPT)
                        : (st.mode == lbc_pkg::LBC_M_IN_PROMPT)
                        ? (i_btn_up ? lbc_pkg::LBC_M_DSP_PROMPT : lbc_pkg::LBC_M_DEL_PROMPT)
                        : (i_btn_up ? lbc_pkg::LBC_M_ADD_PROMPT : lbc_pkg::LBC_M_IN_PROMPT);
                end else if (i_btn_proceed) begin
                    next_st.sel = lbc_pkg::LBC_IDX_ZERO;
                    next_st.fail = 1'b0;
                    next_st.mode = (st.mode == lbc_pkg::LBC_M_ADD_PROMPT) ? lbc_pkg::LBC_M_ADD_SUB
                        : (st.mode == lbc_pkg::LBC_M_DEL_PROMPT) ? lbc_pkg::LBC_M_DEL_SUB
                        : (st.mode == lbc_pkg::LBC_M_IN_PROMPT) ? lbc_pkg::LBC_M_IN_IDX
                        : lbc_pkg::LBC_M_DSP_IDX;
                end else if (i_btn_exit) begin
                    next_st.exit_pulse = 1'b1;
                end
            end
            lbc_pkg::LBC_M_ADD_SUB, lbc_pkg::LBC_M_DEL_SUB,
            lbc_pkg::LBC_M_IN_IDX, lbc_pkg::LBC_M_DSP_IDX: begin
                if (i_btn_up && nxt_idx < st.count) begin
                    next_st.sel = nxt_idx;
                end else if (i_btn_down && st.sel != lbc_pkg::LBC_IDX_ZERO) begin
                    next_st.sel = st.sel - lbc_pkg::LBC_IDX_ONE;
                end else if (i_btn_exit) begin
                    next_st.last_was_del = (st.mode == lbc_pkg::LBC_M_DEL_SUB)
                        || (st.mode != lbc_pkg::LBC_M_ADD_SUB && st.last_was_del);
                    next_st.mode = (st.mode == lbc_pkg::LBC_M_ADD_SUB) ? lbc_pkg::LBC_M_ADD_PROMPT
                        : (st.mode == lbc_pkg::LBC_M_DEL_SUB) ? lbc_pkg::LBC_M_DEL_PROMPT
                        : (st.mode == lbc_pkg::LBC_M_IN_IDX) ? lbc_pkg::LBC_M_IN_PROMPT
                        : lbc_pkg::LBC_M_DSP_PROMPT;
                end else if (i_btn_proceed) begin
                    if (st.mode == lbc_pkg::LBC_M_ADD_SUB) begin
                        if (st.count < lbc_pkg::LBC_MAX_CNT) begin
                            // Shift entries at and above sel up by one; the copy keeps old values
                            for (int k = lbc_pkg::LBC_MAX_PTS - 1; k > 0; k--) begin
                                if (5'(k) > st.sel) begin
                                    next_st.cur[k*16 +: 16] = st.cur[(k-1)*16 +: 16];
                                    next_st.dsp[k*20 +: 20] = st.dsp[(k-1)*20 +: 20];
                                end
                            end
                            next_st.count = st.count + lbc_pkg::LBC_IDX_ONE;
                        end
                    end else if (st.mode == lbc_pkg::LBC_M_DEL_SUB) begin
                        if (st.count > lbc_pkg::LBC_MIN_CNT) begin
                            for (int k = 0; k < lbc_pkg::LBC_MAX_PTS - 1; k++) begin
                                if (5'(k) >= st.sel) begin
                                    next_st.cur[k*16 +: 16] = st.cur[(k+1)*16 +: 16];
                                    next_st.dsp[k*20 +: 20] = st.dsp[(k+1)*20 +: 20];
                                end
                            end
                            next_st.count = st.count - lbc_pkg::LBC_IDX_ONE;
                            if (st.sel == st.count - lbc_pkg::LBC_IDX_ONE) begin
                                next_st.sel = st.sel - lbc_pkg::LBC_IDX_ONE;
                            end
                        end
                    end else begin
                        // Open digit editing from the stored value
                        next_st.digit = lbc_pkg::LBC_DIG_ZERO;
                        next_st.fail = 1'b0;
                        next_st.edit = (st.mode == lbc_pkg::LBC_M_IN_IDX)
                            ? {4'h0, cur_tab[st.sel]} : dsp_tab[st.sel];
                        next_st.mode = (st.mode == lbc_pkg::LBC_M_IN_IDX)
                            ? lbc_pkg::LBC_M_IN_EDIT : lbc_pkg::LBC_M_DSP_EDIT;
                    end
                end
            end
            lbc_pkg::LBC_M_IN_EDIT, lbc_pkg::LBC_M_DSP_EDIT: begin
                // Up/down step the value; proceed moves the digit cursor only
                if (i_btn_up) begin
                    next_st.edit = (st.mode == lbc_pkg::LBC_M_IN_EDIT)
                        ? {4'h0, cand + lbc_pkg::LBC_CUR_STEP} : st.edit + lbc_pkg::LBC_DSP_STEP;
                end else if (i_btn_down) begin
                    next_st.edit = (st.mode == lbc_pkg::LBC_M_IN_EDIT)
                        ? {4'h0, cand - lbc_pkg::LBC_CUR_STEP} : st.edit - lbc_pkg::LBC_DSP_STEP;
                end else if (i_btn_proceed) begin
                    next_st.digit = (st.digit == lbc_pkg::LBC_DIGITS - 3'h1)
                        ? lbc_pkg::LBC_DIG_ZERO : st.digit + 3'h1;
                end else if (i_btn_exit) begin
                    if (st.mode == lbc_pkg::LBC_M_IN_EDIT) begin
                        if (cand_ok) begin
                            next_st.cur[st.sel*16 +: 16] = cand;
                        end else begin
                            next_st.fail = 1'b1;
                        end
                        next_st.mode = lbc_pkg::LBC_M_IN_IDX;
                    end else begin
                        next_st.dsp[st.sel*20 +: 20] = st.edit;
                        next_st.mode = lbc_pkg::LBC_M_DSP_IDX;
                    end
                end
            end
            default: begin
                next_st.mode = lbc_pkg::LBC_M_ADD_PROMPT;
            end
        endcase
        if (i_enter_menu) begin
            next_st.mode = st.last_was_del ? lbc_pkg::LBC_M_DEL_PROMPT : lbc_pkg::LBC_M_ADD_PROMPT;
        end
        // Restore overrides count, sel and points 0 and 1 in the same cycle; menu mode changes still apply
        if (i_restore_defaults_cmd) begin
            next_st.count = lbc_pkg::LBC_MIN_CNT;
            next_st.sel = lbc_pkg::LBC_IDX_ZERO;
            next_st.cur[15:0] = lbc_pkg::LBC_DEF_CUR0;
            next_st.cur[31:16] = lbc_pkg::LBC_DEF_CUR1;
            next_st.dsp[19:0] = lbc_pkg::LBC_DEF_DSP0;
            next_st.dsp[39:20] = i_five_digit ? lbc_pkg::LBC_DEF_DSP1_5D
                : lbc_pkg::LBC_DEF_DSP1_4D;
        end
        // Output path; range test identical for both functions
        next_st.over = src > dsp_max;
        next_st.under = src < -dsp_max;
        next_st.point_value_subfn = (src > dsp_max) ? dsp_max : (src < -dsp_max) ? -dsp_max : src;
        next_st.low = i_loop_current < lbc_pkg::LBC_CUR_LOW;
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Table is kept across linear/linearised changes: only reset and restore load the defaults
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st <= '0;
            st.mode <= lbc_pkg::LBC_M_ADD_PROMPT;
            st.count <= lbc_pkg::LBC_MIN_CNT;
            st.cur[15:0] <= lbc_pkg::LBC_DEF_CUR0;
            st.cur[31:16] <= lbc_pkg::LBC_DEF_CUR1;
            st.dsp[39:20] <= lbc_pkg::LBC_DEF_DSP1_4D;
        end else begin
            st <= next_st;
        end
    end

    assign o_menu_state = st.mode;
    assign o_sel_index = st.sel;
    assign o_point_count = st.count;
    assign o_edit_digit = st.digit;
    assign o_edit_value = st.edit;
    assign o_fail_msg = st.fail;
    assign o_menu_exit = st.exit_pulse;
    assign o_display_value = st.point_value_subfn;
    assign o_over_range = st.over;
    assign o_under_range = st.under;
    assign o_low_loop_power_msg = st.low;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    count_bounds_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.count >= lbc_pkg::LBC_MIN_CNT) && (st.count <= lbc_pkg::LBC_MAX_CNT))
        else $error("point count out of bounds");
    add_grows_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.mode == lbc_pkg::LBC_M_ADD_SUB) && i_btn_proceed && !i_btn_up && !i_btn_down
        && !i_btn_exit && !i_restore_defaults_cmd && !i_enter_menu
        && (st.count < lbc_pkg::LBC_MAX_CNT) |=> st.count == $past(st.count) + 5'h01)
        else $error("add did not grow table");
    del_floor_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.mode == lbc_pkg::LBC_M_DEL_SUB) && (st.count == lbc_pkg::LBC_MIN_CNT)
        && !i_restore_defaults_cmd |=> st.count == lbc_pkg::LBC_MIN_CNT)
        else $error("delete went below two points");
    reject_keeps_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.mode == lbc_pkg::LBC_M_IN_EDIT) && i_btn_exit && !i_btn_up && !i_btn_down
        && !i_btn_proceed && !cand_ok && !i_restore_defaults_cmd
        |=> o_fail_msg && $stable(st.cur))
        else $error("rejected entry changed table");
    window_check_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.mode == lbc_pkg::LBC_M_IN_EDIT) && i_btn_exit && !i_btn_up && !i_btn_down
        && !i_btn_proceed && !i_restore_defaults_cmd
        && ((cand < lbc_pkg::LBC_CUR_MIN) || (cand > lbc_pkg::LBC_CUR_MAX))
        |=> o_fail_msg && $stable(st.cur))
        else $error("current outside window accepted");
    del_shrinks_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.mode == lbc_pkg::LBC_M_DEL_SUB) && i_btn_proceed && !i_btn_up && !i_btn_down
        && !i_btn_exit && !i_restore_defaults_cmd && !i_enter_menu
        && (st.count > lbc_pkg::LBC_MIN_CNT)
        |=> st.count == $past(st.count) - lbc_pkg::LBC_IDX_ONE)
        else $error("delete did not shrink table");
    menu_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.mode == lbc_pkg::LBC_M_DSP_PROMPT) && i_btn_exit && !i_btn_up && !i_btn_down
        && !i_btn_proceed |=> o_menu_exit)
        else $error("exit from prompt not signalled");
    sel_in_table_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st.sel < st.count)
        else $error("selection beyond table");
    low_power_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_loop_current < lbc_pkg::LBC_CUR_LOW) |=> o_low_loop_power_msg)
        else $error("low loop power not shown");
    restore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_restore_defaults_cmd |=> (st.count == lbc_pkg::LBC_MIN_CNT)
        && (cur_tab[0] == lbc_pkg::LBC_DEF_CUR0) && (cur_tab[1] == lbc_pkg::LBC_DEF_CUR1))
        else $error("restore did not load defaults");
    exit_add_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.mode == lbc_pkg::LBC_M_ADD_SUB) && i_btn_exit && !i_btn_up && !i_btn_down
        && !i_enter_menu |=> st.mode == lbc_pkg::LBC_M_ADD_PROMPT)
        else $error("exit did not return to add prompt");
endmodule // lbc_lineariser

`default_nettype wire

// file: bench/lbc_operator.sv
// Front-panel operator model: turns press requests into button pulses.
// Assumes the bench calls push from one thread only, so presses never overlap.
`timescale 1ns/10ps
`default_nettype none
module lbc_operator (
    input wire logic i_clk,
    output logic o_btn_up,
    output logic o_btn_down,
    output logic o_btn_proceed,
    output logic o_btn_exit
);
    // --------------------------------
    // Button pulses
    // --------------------------------
    initial begin
        {o_btn_up, o_btn_down, o_btn_proceed, o_btn_exit} = 4'h0;
    end
    // One button, one cycle, launched on the falling edge so the design samples a
    // settled level; a person cannot press two buttons in the same cycle
    task automatic push(input logic [1:0] which);
        @(negedge i_clk);
        {o_btn_up, o_btn_down, o_btn_proceed, o_btn_exit} = 4'h8 >> which;
        @(negedge i_clk);
        {o_btn_up, o_btn_down, o_btn_proceed, o_btn_exit} = 4'h0;
    endtask
endmodule // lbc_operator
`default_nettype wire

// file: bench/lbc_lineariser_tb.sv
// Self-checking bench for the break-point lineariser and its set-up menu.
// Assumes the operator model drives every button; the bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
module lbc_lineariser_tb;
    localparam logic [1:0] UP = 2'h0;
    localparam logic [1:0] DN = 2'h1;
    localparam logic [1:0] GO = 2'h2;
    localparam logic [1:0] EX = 2'h3;
    logic i_clk, i_rst_n, i_enter_menu, i_restore_defaults_cmd, i_five_digit, i_lin_enable;
    logic up, dn, go, ex;
    logic [15:0] i_loop_current;
    logic signed [19:0] i_linear_value, o_display_value;
    logic [9:0] o_menu_state;
    logic [4:0] o_sel_index, o_point_count;
    logic [2:0] o_edit_digit;
    logic [19:0] o_edit_value;
    logic o_fail_msg, o_menu_exit, o_over_range, o_under_range, o_low_loop_power_msg;
    int num_errors = 0;
    int cmp_count = 0;
    lbc_operator op (.i_clk(i_clk), .o_btn_up(up), .o_btn_down(dn), .o_btn_proceed(go),
        .o_btn_exit(ex));
    lbc_lineariser dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_btn_up(up), .i_btn_down(dn),
        .i_btn_proceed(go), .i_btn_exit(ex), .i_enter_menu(i_enter_menu),
        .i_restore_defaults_cmd(i_restore_defaults_cmd), .i_five_digit(i_five_digit),
        .i_lin_enable(i_lin_enable), .i_loop_current(i_loop_current),
        .i_linear_value(i_linear_value), .o_menu_state(o_menu_state),
        .o_sel_index(o_sel_index), .o_point_count(o_point_count),
        .o_edit_digit(o_edit_digit), .o_edit_value(o_edit_value), .o_fail_msg(o_fail_msg),
        .o_menu_exit(o_menu_exit), .o_display_value(o_display_value),
        .o_over_range(o_over_range), .o_under_range(o_under_range),
        .o_low_loop_power_msg(o_low_loop_power_msg));
    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic finish_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(input string name, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic st(input logic [9:0] exp);
        cmp("menu state", 20'(exp), 20'(o_menu_state));
    endtask
    task automatic pulse(input logic restore);
        @(negedge i_clk);
        if (restore) i_restore_defaults_cmd = 1'b1;
        else i_enter_menu = 1'b1;
        @(negedge i_clk);
        {i_restore_defaults_cmd, i_enter_menu} = 2'h0;
    endtask
    // Menu order of prompts is not fixed here, so walk up then down with a bound
    task automatic goto_prompt(input logic [9:0] target);
        int n;
        n = 0;
        while (o_menu_state !== target && n < 8) begin
            op.push(n < 4 ? UP : DN);
            n++;
        end
        if (o_menu_state !== target) begin
            num_errors++;
            $display("Error prompt expected %h seen %h", target, o_menu_state);
            finish_test();
        end
    endtask
    // Display is registered one cycle after the input, so allow two edges
    task automatic point_value_subfn(input logic [15:0] cur, input logic [19:0] exp);
        @(negedge i_clk);
        i_loop_current = cur;
        repeat (2) @(negedge i_clk);
        cmp("display", exp, o_display_value);
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_defaults();
        st(lbc_pkg::LBC_M_ADD_PROMPT);
        cmp("count", 20'h00002, 20'(o_point_count));
        point_value_subfn(16'h0FA0, 20'h00000);
        point_value_subfn(16'h4E20, 20'h003E8);
        point_value_subfn(16'h2EE0, 20'h001F4);
        point_value_subfn(16'h07D0, 20'hFFF83);
        point_value_subfn(16'h5DC0, 20'h004E2);
        point_value_subfn(16'h03E8, 20'hFFF45);
        cmp("low power", 20'h00001, 20'(o_low_loop_power_msg));
        point_value_subfn(16'h0708, 20'hFFF77);
        cmp("low power", 20'h00000, 20'(o_low_loop_power_msg));
        i_five_digit = 1'b1;
        pulse(1'b1);
        point_value_subfn(16'h4E20, lbc_pkg::LBC_DEF_DSP1_5D);
        cmp("over", 20'h00000, 20'(o_over_range));
        i_lin_enable = 1'b0;
        i_linear_value = 20'h186A0;
        point_value_subfn(16'h4E20, lbc_pkg::LBC_DSP_MAX_5D);
        cmp("over", 20'h00001, 20'(o_over_range));
        i_linear_value = 20'hE7960;
        point_value_subfn(16'h4E20, 20'hE7961);
        cmp("under", 20'h00001, 20'(o_under_range));
        {i_five_digit, i_lin_enable} = 2'h1;
        pulse(1'b1);
    endtask
    task automatic t_add_delete();
        op.push(GO);
        st(lbc_pkg::LBC_M_ADD_SUB);
        cmp("sel", 20'h00000, 20'(o_sel_index));
        cmp("count", 20'h00002, 20'(o_point_count));
        op.push(GO);
        cmp("count", 20'h00003, 20'(o_point_count));
        repeat (14) op.push(GO);
        cmp("count", 20'(lbc_pkg::LBC_MAX_CNT), 20'(o_point_count));
        op.push(GO);
        cmp("count", 20'(lbc_pkg::LBC_MAX_CNT), 20'(o_point_count));
        op.push(EX);
        st(lbc_pkg::LBC_M_ADD_PROMPT);
        goto_prompt(lbc_pkg::LBC_M_DEL_PROMPT);
        op.push(GO);
        st(lbc_pkg::LBC_M_DEL_SUB);
        op.push(UP);
        cmp("sel", 20'h00001, 20'(o_sel_index));
        op.push(GO);
        cmp("count", 20'h00010, 20'(o_point_count));
        repeat (14) op.push(GO);
        cmp("count", 20'h00002, 20'(o_point_count));
        op.push(GO);
        cmp("count", 20'h00002, 20'(o_point_count));
        op.push(EX);
        st(lbc_pkg::LBC_M_DEL_PROMPT);
        pulse(1'b0);
        st(lbc_pkg::LBC_M_DEL_PROMPT);
    endtask
    task automatic t_current();
        pulse(1'b1);
        goto_prompt(lbc_pkg::LBC_M_ADD_PROMPT);
        repeat (2) op.push(GO);
        op.push(EX);
        goto_prompt(lbc_pkg::LBC_M_IN_PROMPT);
        op.push(GO);
        st(lbc_pkg::LBC_M_IN_IDX);
        cmp("sel", 20'h00000, 20'(o_sel_index));
        cmp("count", 20'h00003, 20'(o_point_count));
        op.push(UP);
        op.push(GO);
        cmp("edit", 20'h00FA0, o_edit_value);
        op.push(GO);
        cmp("digit", 20'h00001, 20'(o_edit_digit));
        op.push(EX);
        st(lbc_pkg::LBC_M_IN_IDX);
        cmp("fail", 20'h00001, 20'(o_fail_msg));
        op.push(GO);
        op.push(UP);
        op.push(EX);
        cmp("fail", 20'h00000, 20'(o_fail_msg));
        op.push(DN);
        op.push(GO);
        repeat (201) op.push(DN);
        op.push(EX);
        cmp("fail", 20'h00001, 20'(o_fail_msg));
        op.push(GO);
        cmp("edit", 20'h00FA0, o_edit_value);
        op.push(EX);
        pulse(1'b0);
    endtask
    task automatic t_value();
        pulse(1'b1);
        goto_prompt(lbc_pkg::LBC_M_DSP_PROMPT);
        op.push(GO);
        st(lbc_pkg::LBC_M_DSP_IDX);
        op.push(UP);
        op.push(GO);
        cmp("edit", 20'h003E8, o_edit_value);
        repeat (5) op.push(UP);
        op.push(EX);
        st(lbc_pkg::LBC_M_DSP_IDX);
        op.push(EX);
        st(lbc_pkg::LBC_M_DSP_PROMPT);
        op.push(EX);
        cmp("menu exit", 20'h00001, 20'(o_menu_exit));
        i_lin_enable = 1'b0;
        i_linear_value = 20'h00123;
        point_value_subfn(16'h4E20, 20'h00123);
        i_lin_enable = 1'b1;
        point_value_subfn(16'h4E20, 20'h003ED);
    endtask
    // --------------------------------
    // Clock, reset and sequence
    // --------------------------------
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, i_enter_menu, i_restore_defaults_cmd, i_five_digit} = 4'h0;
        i_lin_enable = 1'b1;
        i_loop_current = 16'h0FA0;
        i_linear_value = 20'h00000;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_defaults();
        t_add_delete();
        t_current();
        t_value();
        finish_test();
    end
endmodule // lbc_lineariser_tb
`default_nettype wire
